/* File: src/scg_pkg.sv */
/*
  Constants for the sleep-mode clock gating block: register offsets,
  field positions, reset values, bus answers and power-mode codes.
  Assumes a 32-bit Avalon-MM slave port with byte addressing.
*/
// What this block does
// - A gate bit of 1 in the governing register clocks that unit.
// - A gate bit of 0 stops the unit clock and holds it disabled.
// - Accesses aimed at an unclocked unit are answered with a bus fault.
// - Every gate bit resets to 0, so all units start unclocked.
// - Three gate registers exist: run, sleep at 0x118, deep-sleep.
// - Sleep gate registers apply only when auto gate select is set.
// - Bits 31, 29 and 27:8 read 0 and ignore writes.
// - Port A to port H gates sit at bits 0 to 7.
// - Ethernet PHY gate is bit 30, Ethernet MAC gate is bit 28.
// - The sleep gate register is a 32-bit register at offset 0x118.
`default_nettype none
package scg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] RUN_CFG_OFS = 12'h060;
  localparam logic [11:0] RUN_GATE_OFS = 12'h108;
  localparam logic [11:0] SLEEP_GATE_OFS = 12'h118;
  localparam logic [11:0] DEEP_GATE_OFS = 12'h128;
  localparam logic [11:0] ACTIVE_GATE_OFS = 12'h130;
  localparam logic [11:0] INT_STATUS_OFS = 12'h140;
  localparam logic [11:0] INT_MASK_OFS = 12'h144;
  localparam logic [11:0] FAULT_UNIT_OFS = 12'h148;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] GATE_RW_MASK = 32'h5000_00ff;
  localparam logic [31:0] RUN_CFG_RESET = 32'h0000_0000;
  localparam int unsigned PORT_LSB = 0;
  localparam int unsigned PORT_N = 8;
  localparam int unsigned MAC_BIT = 28;
  localparam int unsigned PHY_BIT = 30;
  localparam int unsigned ACG_BIT = 27;
  localparam int unsigned UNIT_N = 10;
  localparam int unsigned MAC_UNIT = 8;
  localparam int unsigned PHY_UNIT = 9;
  localparam logic [9:0] FAULT_UNIT_RESET = 10'h000;

  // ----------------------------------------------------------------
  // Interrupt status layout
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_N = 3;
  localparam int unsigned IRQ_UNIT_FAULT = 0;
  localparam int unsigned IRQ_DECODE_ERR = 1;
  localparam int unsigned IRQ_MODE_CHG = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Bus answers and power-mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_DEEP = 2'h2;

  typedef enum logic [1:0] {
    SCG_RUN,
    SCG_SLEEP,
    SCG_DEEP
  } scg_mode_e;

endpackage
`default_nettype wire

/* File: src/scg_top.sv */
/*
  Sleep-mode clock gating controller: run, sleep and deep-sleep gate
  registers, the auto gate select bit, the applied gate enables, the
  bus fault check for accesses to unclocked units and an interrupt.
  Assumes an Avalon-MM master on clk_sys_i and power mode and unit
  access inputs from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module scg_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  // Power mode request
  input wire logic [1:0] power_mode_i,
  // Unit access check
  input wire logic unit_access_i,
  input wire logic [9:0] unit_sel_i,
  output logic unit_fault_o,
  // Unit clock enables
  output logic [7:0] port_clk_en_o,
  output logic eth_mac_clk_en_o,
  output logic eth_phy_clk_en_o,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic wait_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic [31:0] run_gate_q;
  logic [31:0] sleep_gate_q;
  logic [31:0] deep_gate_q;
  logic [31:0] run_cfg_q;
  logic [31:0] active_q;
  logic [31:0] active_d;
  scg_pkg::scg_mode_e mode_q;
  scg_pkg::scg_mode_e mode_d;
  logic [2:0] stat_q;
  logic [2:0] stat_d;
  logic [2:0] mask_q;
  logic [9:0] fault_unit_q;
  logic fault_q;
  logic irq_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic take;
  logic wr_take;
  logic rd_take;
  logic hit_cfg;
  logic hit_run;
  logic hit_sleep;
  logic hit_deep;
  logic hit_active;
  logic hit_stat;
  logic hit_mask;
  logic hit_funit;
  logic hit_any;
  logic [31:0] be_mask;
  logic [31:0] rd_mux;

  assign take = (avs_read_i | avs_write_i) & wait_q;
  assign wr_take = take & avs_write_i;
  assign rd_take = take & avs_read_i;

  assign hit_cfg = avs_address_i == scg_pkg::RUN_CFG_OFS;
  assign hit_run = avs_address_i == scg_pkg::RUN_GATE_OFS;
  assign hit_sleep = avs_address_i == scg_pkg::SLEEP_GATE_OFS;
  assign hit_deep = avs_address_i == scg_pkg::DEEP_GATE_OFS;
  assign hit_active = avs_address_i == scg_pkg::ACTIVE_GATE_OFS;
  assign hit_stat = avs_address_i == scg_pkg::INT_STATUS_OFS;
  assign hit_mask = avs_address_i == scg_pkg::INT_MASK_OFS;
  assign hit_funit = avs_address_i == scg_pkg::FAULT_UNIT_OFS;
  assign hit_any = hit_cfg | hit_run | hit_sleep | hit_deep | hit_active |
                   hit_stat | hit_mask | hit_funit;

  // Byte enables widened to a bit mask
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign be_mask[gb*8 +: 8] = {8{avs_byteenable_i[gb]}};
    end
  endgenerate

  // Merge of a gate register write; reserved bits stay zero
  function automatic logic [31:0] gate_merge(
    input logic [31:0] old_v,
    input logic [31:0] wd,
    input logic [31:0] bm
  );
    logic [31:0] wm;
    wm = bm & scg_pkg::GATE_RW_MASK;
    gate_merge = (old_v & ~wm) | (wd & wm);
  endfunction

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_cfg) begin
      rd_mux = run_cfg_q;
    end
    if (hit_run) begin
      rd_mux = run_gate_q;
    end
    if (hit_sleep) begin
      rd_mux = sleep_gate_q;
    end
    if (hit_deep) begin
      rd_mux = deep_gate_q;
    end
    if (hit_active) begin
      rd_mux = active_q;
    end
    if (hit_stat) begin
      rd_mux = {29'h0000_0000, stat_q};
    end
    if (hit_mask) begin
      rd_mux = {29'h0000_0000, mask_q};
    end
    if (hit_funit) begin
      rd_mux = {22'h00_0000, fault_unit_q};
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake: answer one cycle after the request is seen
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_q <= 1'b1;
    end else if (take) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_q <= rd_mux;
    end else if (wr_take) begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // Unmapped addresses answer with a decode error
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      resp_q <= scg_pkg::RESP_OKAY;
    end else if (take) begin
      resp_q <= hit_any ? scg_pkg::RESP_OKAY : scg_pkg::RESP_DECERR;
    end
  end

  // ----------------------------------------------------------------
  // Gate registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_gate_q <= scg_pkg::GATE_RESET;
    end else if (wr_take && hit_run) begin
      run_gate_q <= gate_merge(run_gate_q, avs_writedata_i, be_mask);
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sleep_gate_q <= scg_pkg::GATE_RESET;
    end else if (wr_take && hit_sleep) begin
      sleep_gate_q <= gate_merge(sleep_gate_q, avs_writedata_i, be_mask);
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      deep_gate_q <= scg_pkg::GATE_RESET;
    end else if (wr_take && hit_deep) begin
      deep_gate_q <= gate_merge(deep_gate_q, avs_writedata_i, be_mask);
    end
  end

  // Run clock configuration: only the auto gate select bit is kept
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_cfg_q <= scg_pkg::RUN_CFG_RESET;
    end else if (wr_take && hit_cfg && avs_byteenable_i[3]) begin
      run_cfg_q[scg_pkg::ACG_BIT] <= avs_writedata_i[scg_pkg::ACG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Power mode and governing register
  // ----------------------------------------------------------------
  // Codes other than sleep and deep sleep run as run mode
  always_comb begin
    mode_d = scg_pkg::SCG_RUN;
    if (power_mode_i == scg_pkg::MODE_SLEEP) begin
      mode_d = scg_pkg::SCG_SLEEP;
    end
    if (power_mode_i == scg_pkg::MODE_DEEP) begin
      mode_d = scg_pkg::SCG_DEEP;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= scg_pkg::SCG_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_comb begin
    active_d = run_gate_q;
    if (run_cfg_q[scg_pkg::ACG_BIT]) begin
      unique case (mode_q)
        scg_pkg::SCG_RUN: active_d = run_gate_q;
        scg_pkg::SCG_SLEEP: active_d = sleep_gate_q;
        scg_pkg::SCG_DEEP: active_d = deep_gate_q;
      endcase
    end
  end

  // Applied gates are registered so each enable leaves a flop
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_q <= scg_pkg::GATE_RESET;
    end else begin
      active_q <= active_d;
    end
  end

  // ----------------------------------------------------------------
  // Unit clock enables
  // ----------------------------------------------------------------
  logic [9:0] unit_en;

  assign unit_en = {active_q[scg_pkg::PHY_BIT],
                    active_q[scg_pkg::MAC_BIT],
                    active_q[scg_pkg::PORT_LSB +: scg_pkg::PORT_N]};

  // Enable high runs the unit, low stops and disables it
  assign port_clk_en_o = unit_en[7:0];
  assign eth_mac_clk_en_o = unit_en[scg_pkg::MAC_UNIT];
  assign eth_phy_clk_en_o = unit_en[scg_pkg::PHY_UNIT];

  // ----------------------------------------------------------------
  // Fault on access to an unclocked unit
  // ----------------------------------------------------------------
  logic fault_hit;

  assign fault_hit = unit_access_i & (|(unit_sel_i & ~unit_en));

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_hit;
    end
  end

  // Last faulting unit vector, read back at its own offset
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_unit_q <= scg_pkg::FAULT_UNIT_RESET;
    end else if (fault_hit) begin
      fault_unit_q <= unit_sel_i & ~unit_en;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [2:0] stat_set;
  logic [2:0] stat_clr;

  always_comb begin
    stat_set = 3'h0;
    stat_set[scg_pkg::IRQ_UNIT_FAULT] = fault_hit;
    stat_set[scg_pkg::IRQ_DECODE_ERR] = take & ~hit_any;
    stat_set[scg_pkg::IRQ_MODE_CHG] = mode_d != mode_q;
    stat_clr = 3'h0;
    if (wr_take && hit_stat && avs_byteenable_i[0]) begin
      stat_clr = avs_writedata_i[2:0];
    end
    // A new event wins over a clear in the same cycle
    stat_d = (stat_q & ~stat_clr) | stat_set;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_q <= scg_pkg::IRQ_RESET;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mask_q <= scg_pkg::IRQ_RESET;
    end else if (wr_take && hit_mask && avs_byteenable_i[0]) begin
      mask_q <= avs_writedata_i[2:0];
    end
  end

  // Level interrupt from the next status, one edge after the event
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_d & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign avs_response_o = resp_q;
  assign unit_fault_o = fault_q;
  assign irq_o = irq_q;

endmodule
`default_nettype wire

/* File: testbench/scg_monitor.sv */
/*
  Checker on the scg_top ports.
  Bound to every scg_top instance below.
*/
`timescale 1ns/100ps
`default_nettype none
module scg_monitor (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Bus
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic [1:0] avs_response_o,
  input wire logic avs_waitrequest_o,
  // Mode, units, enables
  input wire logic [1:0] power_mode_i,
  input wire logic unit_access_i,
  input wire logic [9:0] unit_sel_i,
  input wire logic unit_fault_o,
  input wire logic [7:0] port_clk_en_o,
  input wire logic eth_mac_clk_en_o,
  input wire logic eth_phy_clk_en_o
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  wire logic [9:0] en = {eth_phy_clk_en_o, eth_mac_clk_en_o, port_clk_en_o};
  wire logic ans = !avs_waitrequest_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  AST_BUS_ANSWER: assert property (taken |=> answer)
    else $error("bus answer not one cycle");
  AST_BUS_IDLE: assert property (!(avs_read_i || avs_write_i) |=>
    avs_waitrequest_o) else $error("answer without request");
  AST_RESV_ZERO: assert property (ans && avs_read_i &&
    avs_address_i inside {12'h108, 12'h118, 12'h128} |->
    (avs_readdata_o & 32'hafff_ff00) == 32'h0)
    else $error("reserved gate bit reads one");
  AST_SLEEP_OKAY: assert property (ans && avs_address_i == 12'h118
    |-> avs_response_o == 2'h0) else $error("sleep gate not decoded");
  AST_UNMAPPED: assert property (ans && avs_read_i &&
    avs_address_i == 12'h004 |-> avs_response_o == 2'h3 &&
    avs_readdata_o == 32'h0) else $error("unmapped read answered");
  AST_FAULT: assert property (unit_access_i &&
    |(unit_sel_i & ~en) |=> unit_fault_o) else $error("fault missing");
  AST_NO_FAULT: assert property (unit_fault_o |->
    $past(unit_access_i) && |($past(unit_sel_i) & ~$past(en)))
    else $error("fault on clocked unit");
  AST_EN_CAUSE: assert property ($changed(en) |->
    $past(avs_write_i, 2) || $past(power_mode_i, 2) !=
    $past(power_mode_i, 3)) else $error("enable changed alone");
endmodule
bind scg_top scg_monitor mon_u (
  .clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_response_o(avs_response_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .power_mode_i(power_mode_i),
  .unit_access_i(unit_access_i),
  .unit_sel_i(unit_sel_i),
  .unit_fault_o(unit_fault_o),
  .port_clk_en_o(port_clk_en_o),
  .eth_mac_clk_en_o(eth_mac_clk_en_o),
  .eth_phy_clk_en_o(eth_phy_clk_en_o)
);
`default_nettype wire

/* File: testbench/scg_unit_model.sv */
/*
  Model of the gated units: makes one access pulse aimed at one unit.
  Assumes the bench calls poke on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module scg_unit_model (
  // Clock
  input wire logic clk_i,
  // Access to a unit
  output logic access_o,
  output logic [9:0] sel_o
);
  // ----------------------------------------
  // Access driver
  // ----------------------------------------
  initial begin
    access_o = 1'b0;
    sel_o = 10'h000;
  end
  task automatic poke(input int k);
    @(posedge clk_i);
    access_o <= 1'b1;
    sel_o <= 10'h001 << k;
    @(posedge clk_i);
    access_o <= 1'b0;
    sel_o <= ~(10'h001 << k);
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
/*
  Bench for scg_top: register reset, mask, bit map, modes, faults, irq.
  Assumes scg_unit_model and the bound checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [11:0] addr = 12'h000;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [1:0] mode = 2'h0;
  logic [31:0] rdata;
  logic [1:0] resp;
  logic wreq, acc, flt, mac, phy, irq;
  logic [7:0] port;
  logic [9:0] sel;
  logic [31:0] d;
  logic [1:0] r;
  logic [11:0] ofs [4] = '{12'h060, 12'h108, 12'h118, 12'h128};
  int mismatches = 0;
  int cmp_count = 0;
  wire logic [9:0] en = {phy, mac, port};
  scg_unit_model unit_u (.clk_i(clk_sys_i), .access_o(acc), .sel_o(sel));
  scg_top dut_u (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(addr), .avs_read_i(rd_s), .avs_write_i(wr_s),
    .avs_byteenable_i(4'hf), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_response_o(resp),
    .avs_waitrequest_o(wreq), .power_mode_i(mode),
    .unit_access_i(acc), .unit_sel_i(sel), .unit_fault_o(flt),
    .port_clk_en_o(port), .eth_mac_clk_en_o(mac),
    .eth_phy_clk_en_o(phy), .irq_o(irq));
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] v);
    @(posedge clk_sys_i);
    rd_s <= !w;
    wr_s <= w;
    addr <= a;
    wdata <= v;
    do begin
      @(posedge clk_sys_i);
    end while (wreq !== 1'b0);
    d = rdata;
    r = resp;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic poke(input int k, input logic f);
    unit_u.poke(k);
    #1 chk({31'h0, flt}, {31'h0, f});
  endtask
  task automatic setmode(input logic [1:0] m, input logic [9:0] e);
    @(posedge clk_sys_i);
    mode <= m;
    repeat (3) @(posedge clk_sys_i);
    #1 chk({22'h0, en}, {22'h0, e});
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ofs[i], 32'h0);
      chk(d, 32'h0);
    end
    chk({22'h0, en}, 32'h0);
    bus(1'b0, 12'h004, 32'h0);
    chk({30'h0, r}, 32'h3);
    $display("test reset done");
    for (int i = 1; i < 4; i++) begin
      bus(1'b1, ofs[i], 32'hffff_ffff);
      bus(1'b0, ofs[i], 32'h0);
      chk(d, 32'h5000_00ff);
      bus(1'b1, ofs[i], 32'h0);
    end
    $display("test mask done");
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, 12'h108, i < 8 ? 32'h1 << i : 32'h1 << (12 + 2 * i));
      chk({22'h0, en}, 32'h1 << i);
      poke(i, 1'b0);
      poke((i + 1) % 10, 1'b1);
    end
    $display("test map done");
    bus(1'b1, 12'h108, 32'h1);
    bus(1'b1, 12'h118, 32'h2);
    bus(1'b1, 12'h128, 32'h1000_0000);
    setmode(2'h1, 10'h001);
    bus(1'b1, 12'h060, 32'h0800_0000);
    chk({22'h0, en}, 32'h2);
    setmode(2'h2, 10'h100);
    setmode(2'h3, 10'h001);
    setmode(2'h0, 10'h001);
    $display("test modes done");
    bus(1'b0, 12'h140, 32'h0);
    chk(d, 32'h7);
    bus(1'b1, 12'h140, 32'h7);
    bus(1'b1, 12'h144, 32'h1);
    chk({31'h0, irq}, 32'h0);
    poke(3, 1'b1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, 12'h148, 32'h0);
    chk(d, 32'h8);
    bus(1'b1, 12'h140, 32'h1);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 12'h144, 32'h0);
    poke(3, 1'b1);
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
    close_out;
  end
  initial begin
    #200000;
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
